// [logic/oag_add16.sv]
// address adder with unsigned or sign-extended byte offset
`timescale 1ns/100ps
module oag_add16 #(
  parameter int ADDR_W = 16,
  parameter int BYTE_W = 8
) (
  // operands
  input  wire logic [ADDR_W-1:0] base_in,
  input  wire logic [BYTE_W-1:0] offset_in,
  input  wire logic              signed_in,
  // result
  output logic      [ADDR_W-1:0] sum_out
);

  logic [ADDR_W-1:0] ext;

  // carry runs into the high byte, no page wrap
  always_comb begin
    if (signed_in) begin
      ext = {{(ADDR_W-BYTE_W){offset_in[BYTE_W-1]}}, offset_in};
    end else begin
      ext = {{(ADDR_W-BYTE_W){1'h0}}, offset_in};
    end
    sum_out = base_in + ext;
  end

endmodule

// [logic/oag_mode_map.sv]
// prefix resolution and byte counts per addressing mode
`timescale 1ns/100ps
module oag_mode_map (
  // opcode class and prefix
  input  wire oag_pkg::oag_mode_t base_mode_in,
  input  wire oag_pkg::oag_pfx_t  pfx_in,
  input  wire logic               rmw_in,
  // resolved mode
  output oag_pkg::oag_mode_t      mode_out,
  output logic                    use_y_out,
  output logic                    rel_last_out,
  output logic                    refused_out,
  output logic [1:0]              opnd_cnt_out,
  output logic [1:0]              ptr_cnt_out
);

  logic bad;
  logic long_form;

  always_comb begin
    mode_out  = base_mode_in;
    use_y_out = 1'h0;
    bad       = 1'h0;
    unique case (pfx_in)
      oag_pkg::PFX_NONE: begin
      end
      oag_pkg::PFX_Y: begin
        use_y_out = 1'h1; // RULE19
        bad = !(base_mode_in inside {oag_pkg::MD_INHERENT,
          oag_pkg::MD_IMMEDIATE, oag_pkg::MD_DIR_SHORT,
          oag_pkg::MD_DIR_LONG, oag_pkg::MD_IDX_NONE,
          oag_pkg::MD_IDX_SHORT, oag_pkg::MD_IDX_LONG});
      end
      oag_pkg::PFX_IND: begin
        unique case (base_mode_in) // RULE20
          oag_pkg::MD_DIR_SHORT: mode_out = oag_pkg::MD_IND_SHORT;
          oag_pkg::MD_DIR_LONG:  mode_out = oag_pkg::MD_IND_LONG;
          oag_pkg::MD_BIT:       mode_out = oag_pkg::MD_BIT_IND;
          oag_pkg::MD_BIT_REL:   mode_out = oag_pkg::MD_BIT_IND_REL;
          oag_pkg::MD_REL:       mode_out = oag_pkg::MD_REL_IND;
          oag_pkg::MD_IDX_SHORT: mode_out = oag_pkg::MD_IIDX_SHORT;
          oag_pkg::MD_IDX_LONG:  mode_out = oag_pkg::MD_IIDX_LONG;
          default:               bad = 1'h1;
        endcase
      end
      oag_pkg::PFX_IND_Y: begin
        use_y_out = 1'h1; // RULE21
        unique case (base_mode_in)
          oag_pkg::MD_IDX_SHORT: mode_out = oag_pkg::MD_IIDX_SHORT;
          oag_pkg::MD_IDX_LONG:  mode_out = oag_pkg::MD_IIDX_LONG;
          default:               bad = 1'h1;
        endcase
      end
    endcase
    // bytes after the opcode and pointer bytes read from memory
    opnd_cnt_out = oag_pkg::CNT_ONE;
    ptr_cnt_out  = oag_pkg::CNT_ZERO;
    rel_last_out = 1'h0;
    long_form    = 1'h0;
    unique case (mode_out)
      oag_pkg::MD_INHERENT, oag_pkg::MD_IDX_NONE:
        opnd_cnt_out = oag_pkg::CNT_ZERO; // RULE1 RULE6
      oag_pkg::MD_IMMEDIATE, oag_pkg::MD_DIR_SHORT, oag_pkg::MD_IDX_SHORT,
      oag_pkg::MD_BIT: begin
        opnd_cnt_out = oag_pkg::CNT_ONE; // RULE2 RULE3 RULE8
      end
      oag_pkg::MD_DIR_LONG, oag_pkg::MD_IDX_LONG: begin
        opnd_cnt_out = oag_pkg::CNT_TWO; // RULE4 RULE9
        long_form    = 1'h1;
      end
      oag_pkg::MD_IND_SHORT, oag_pkg::MD_IIDX_SHORT, oag_pkg::MD_BIT_IND,
      oag_pkg::MD_REL_IND:
        ptr_cnt_out = oag_pkg::CNT_ONE; // RULE11 RULE14
      oag_pkg::MD_IND_LONG, oag_pkg::MD_IIDX_LONG: begin
        ptr_cnt_out = oag_pkg::CNT_TWO; // RULE12
        long_form   = 1'h1;
      end
      oag_pkg::MD_REL:
        rel_last_out = 1'h1; // RULE15
      oag_pkg::MD_BIT_REL: begin
        opnd_cnt_out = oag_pkg::CNT_TWO;
        rel_last_out = 1'h1;
      end
      oag_pkg::MD_BIT_IND_REL: begin
        opnd_cnt_out = oag_pkg::CNT_TWO;
        ptr_cnt_out  = oag_pkg::CNT_ONE;
        rel_last_out = 1'h1;
      end
      default: begin
        opnd_cnt_out = oag_pkg::CNT_ZERO;
        bad          = 1'h1;
      end
    endcase
    refused_out = bad || (rmw_in && long_form); // RULE18
  end

endmodule

// [logic/oag_operand_address_generator.sv]
// operand address generator: prefix, operand bytes, pointers, address
// Operation
// [RULE1] inherent instruction is the opcode byte alone
// [RULE2] immediate instruction is opcode plus one operand value byte
// [RULE3] short direct fetches one address byte, page zero only
// [RULE4] long direct fetches a two-byte address word, full space
// [RULE5] indexed address is unsigned sum of index and offset
// [RULE6] no-offset indexed fetches nothing, index alone is the address
// [RULE7] second index in no-offset indexed costs one extra byte
// [RULE8] short indexed adds one offset byte to index, up to 1FE
// [RULE9] long indexed adds index to a two-byte offset word
// [RULE10] indirect reads the address from a pointer named after opcode
// [RULE11] short indirect reads a one-byte pointer from page zero
// [RULE12] long indirect reads a two-byte pointer from page zero
// [RULE13] indirect indexed adds index to the pointer from memory
// [RULE14] short indirect indexed adds byte pointer to index, up to 1FE
// [RULE15] relative target is next instruction plus signed byte offset
// [RULE16] short forms reach page zero with fewer bytes
// [RULE17] long forms reach the whole space with more bytes
// [RULE18] read-modify-write instructions accept short forms only
// [RULE19] prefix 90 selects the second index register
// [RULE20] prefix 92 turns direct and indexed forms indirect
// [RULE21] prefix 91 does indirect indexed with the second index
// [RULE22] addresses are 16 bits with carry; word pointers high first
`timescale 1ns/100ps
module oag_operand_address_generator (
  // clock and reset
  input  wire logic                            clock_in,
  input  wire logic                            rst_b_in,
  // instruction byte stream
  input  wire logic                            instr_valid_in,
  input  wire logic [oag_pkg::BYTE_W-1:0]      instr_byte_in,
  input  wire logic [oag_pkg::ADDR_W-1:0]      instr_pc_in,
  output logic                                 fetch_ready_out,
  // opcode class
  input  wire oag_pkg::oag_mode_t              opc_mode_in,
  input  wire logic                            opc_rmw_in,
  // index registers
  input  wire logic [oag_pkg::BYTE_W-1:0]      index_x_in,
  input  wire logic [oag_pkg::BYTE_W-1:0]      index_y_in,
  // pointer read port
  output logic                                 mem_req_out,
  output logic [oag_pkg::ADDR_W-1:0]           mem_addr_out,
  input  wire logic                            mem_ack_in,
  input  wire logic [oag_pkg::BYTE_W-1:0]      mem_data_in,
  // result
  output logic                                 done_out,
  output oag_pkg::oag_mode_t                   mode_out,
  output logic                                 index_y_out,
  output logic                                 refused_out,
  output logic [oag_pkg::LEN_W-1:0]            length_out,
  output logic [oag_pkg::ADDR_W-1:0]           ea_out,
  output logic                                 ea_valid_out,
  output logic [oag_pkg::BYTE_W-1:0]           imm_out,
  output logic                                 imm_valid_out,
  output logic [oag_pkg::ADDR_W-1:0]           target_out,
  output logic                                 target_valid_out
);

  localparam int AW = oag_pkg::ADDR_W;
  localparam int BW = oag_pkg::BYTE_W;
  localparam int LW = oag_pkg::LEN_W;

  typedef struct packed {
    oag_pkg::oag_state_t state;
    logic                ready;
    oag_pkg::oag_pfx_t   pfx;
    oag_pkg::oag_mode_t  mode;
    logic                rmw;
    logic                use_y;
    logic                refused;
    logic                rel_last;
    logic [1:0]          opnd_cnt;
    logic [1:0]          ptr_cnt;
    logic [LW-1:0]       len;
    logic [LW-1:0]       length;
    logic [AW-1:0]       pc_start;
    logic [AW-1:0]       opnd;
    logic [AW-1:0]       ptr;
    logic [BW-1:0]       rel_off;
    logic                mem_req;
    logic [AW-1:0]       mem_addr;
    logic                done;
    logic [AW-1:0]       ea;
    logic                ea_valid;
    logic [BW-1:0]       imm;
    logic                imm_valid;
    logic [AW-1:0]       target;
    logic                target_valid;
  } oag_regs_t;

  oag_regs_t          st_q;
  oag_regs_t          st_d;
  oag_pkg::oag_mode_t map_mode;
  logic               map_use_y;
  logic               map_rel_last;
  logic               map_refused;
  logic [1:0]         map_opnd_cnt;
  logic [1:0]         map_ptr_cnt;
  logic [BW-1:0]      idx_sel;
  logic [AW-1:0]      idx_base;
  logic [AW-1:0]      idx_sum;
  logic [AW-1:0]      next_pc;
  logic [AW-1:0]      target_sum;
  logic [BW-1:0]      ptr_loc;
  logic               taken;

  // prefix and mode resolution for the byte now offered
  oag_mode_map u_mode_map (
    .base_mode_in (opc_mode_in),
    .pfx_in       (st_q.pfx),
    .rmw_in       (opc_rmw_in),
    .mode_out     (map_mode),
    .use_y_out    (map_use_y),
    .rel_last_out (map_rel_last),
    .refused_out  (map_refused),
    .opnd_cnt_out (map_opnd_cnt),
    .ptr_cnt_out  (map_ptr_cnt)
  );

  assign idx_sel = st_q.use_y ? index_y_in : index_x_in;
  assign next_pc = st_q.pc_start + {{(AW-LW){1'h0}}, st_q.len};
  assign ptr_loc = st_q.rel_last ? st_q.opnd[BW-1:0] : instr_byte_in;
  assign taken   = instr_valid_in && st_q.ready;

  // base that the index register is added to
  always_comb begin
    unique case (st_q.mode)
      oag_pkg::MD_IDX_SHORT:
        idx_base = {oag_pkg::PAGE_ZERO_HI, st_q.opnd[BW-1:0]}; // RULE8
      oag_pkg::MD_IDX_LONG:   idx_base = st_q.opnd; // RULE9
      oag_pkg::MD_IIDX_SHORT:
        idx_base = {oag_pkg::PAGE_ZERO_HI, st_q.ptr[BW-1:0]}; // RULE14
      oag_pkg::MD_IIDX_LONG:  idx_base = st_q.ptr; // RULE13
      default:                idx_base = '0; // RULE6
    endcase
  end

  oag_add16 #(
    .ADDR_W (AW),
    .BYTE_W (BW)
  ) u_idx_add (
    .base_in   (idx_base),
    .offset_in (idx_sel),
    .signed_in (1'h0),
    .sum_out   (idx_sum)
  );

  oag_add16 #(
    .ADDR_W (AW),
    .BYTE_W (BW)
  ) u_rel_add (
    .base_in   (next_pc),
    .offset_in (st_q.rel_off),
    .signed_in (1'h1),
    .sum_out   (target_sum)
  );

  always_comb begin
    st_d      = st_q;
    st_d.done = 1'h0;
    unique case (st_q.state)
      oag_pkg::ST_IDLE: begin
        st_d.ready = 1'h1;
        if (taken) begin
          st_d.len = st_q.len + oag_pkg::LEN_STEP; // RULE7
          if (st_q.pfx == oag_pkg::PFX_NONE) begin
            st_d.pc_start = instr_pc_in;
          end
          if (st_q.pfx == oag_pkg::PFX_NONE &&
              instr_byte_in == oag_pkg::SECOND_INDEX_PREFIX) begin
            st_d.pfx = oag_pkg::PFX_Y; // RULE19
          end else if (st_q.pfx == oag_pkg::PFX_NONE &&
                       instr_byte_in == oag_pkg::INDIRECT_PREFIX) begin
            st_d.pfx = oag_pkg::PFX_IND; // RULE20
          end else if (st_q.pfx == oag_pkg::PFX_NONE &&
              instr_byte_in == oag_pkg::INDIRECT_SECOND_INDEX_PREFIX) begin
            st_d.pfx = oag_pkg::PFX_IND_Y; // RULE21
          end else begin
            st_d.mode     = map_mode;
            st_d.rmw      = opc_rmw_in;
            st_d.use_y    = map_use_y;
            st_d.refused  = map_refused;
            st_d.rel_last = map_rel_last;
            st_d.opnd_cnt = map_opnd_cnt;
            st_d.ptr_cnt  = map_ptr_cnt;
            st_d.opnd     = '0;
            st_d.ptr      = '0;
            st_d.rel_off  = '0;
            if (map_opnd_cnt != oag_pkg::CNT_ZERO) begin
              st_d.state = oag_pkg::ST_OPND;
            end else begin
              st_d.state = oag_pkg::ST_CALC; // RULE1 RULE6
              st_d.ready = 1'h0;
            end
          end
        end
      end
      oag_pkg::ST_OPND: begin
        if (taken) begin
          st_d.len      = st_q.len + oag_pkg::LEN_STEP;
          st_d.opnd_cnt = st_q.opnd_cnt - oag_pkg::CNT_ONE;
          if (st_q.rel_last && st_q.opnd_cnt == oag_pkg::CNT_ONE) begin
            st_d.rel_off = instr_byte_in; // RULE15
          end else begin
            st_d.opnd = {st_q.opnd[BW-1:0], instr_byte_in}; // RULE4 RULE9
          end
          if (st_q.opnd_cnt == oag_pkg::CNT_ONE) begin
            st_d.ready = 1'h0;
            if (st_q.ptr_cnt != oag_pkg::CNT_ZERO) begin
              st_d.state    = oag_pkg::ST_PTR;
              st_d.mem_req  = 1'h1;
              st_d.mem_addr = {oag_pkg::PAGE_ZERO_HI, ptr_loc}; // RULE10
            end else begin
              st_d.state = oag_pkg::ST_CALC;
            end
          end
        end
      end
      oag_pkg::ST_PTR: begin
        if (mem_ack_in) begin
          st_d.ptr_cnt = st_q.ptr_cnt - oag_pkg::CNT_ONE;
          if (st_q.mode == oag_pkg::MD_REL_IND) begin
            st_d.rel_off = mem_data_in;
          end else begin
            st_d.ptr = {st_q.ptr[BW-1:0], mem_data_in}; // RULE22
          end
          if (st_q.ptr_cnt == oag_pkg::CNT_ONE) begin
            st_d.mem_req = 1'h0;
            st_d.state   = oag_pkg::ST_CALC;
          end else begin
            st_d.mem_addr = st_q.mem_addr + oag_pkg::ADDR_STEP; // RULE12
          end
        end
      end
      oag_pkg::ST_CALC: begin
        st_d.state        = oag_pkg::ST_IDLE;
        st_d.ready        = 1'h1;
        st_d.pfx          = oag_pkg::PFX_NONE;
        st_d.len          = '0;
        st_d.length       = st_q.len;
        st_d.done         = 1'h1;
        st_d.ea           = '0;
        st_d.ea_valid     = 1'h0;
        st_d.imm          = '0;
        st_d.imm_valid    = 1'h0;
        st_d.target       = '0;
        st_d.target_valid = 1'h0;
        if (!st_q.refused) begin // RULE18
          unique case (st_q.mode)
            oag_pkg::MD_INHERENT: begin // RULE1
            end
            oag_pkg::MD_IMMEDIATE: begin
              st_d.imm       = st_q.opnd[BW-1:0]; // RULE2
              st_d.imm_valid = 1'h1;
            end
            oag_pkg::MD_DIR_SHORT, oag_pkg::MD_BIT: begin // RULE3 RULE16
              st_d.ea = {oag_pkg::PAGE_ZERO_HI, st_q.opnd[BW-1:0]};
              st_d.ea_valid = 1'h1;
            end
            oag_pkg::MD_BIT_REL: begin
              st_d.ea = {oag_pkg::PAGE_ZERO_HI, st_q.opnd[BW-1:0]};
              st_d.ea_valid     = 1'h1;
              st_d.target       = target_sum;
              st_d.target_valid = 1'h1;
            end
            oag_pkg::MD_DIR_LONG: begin
              st_d.ea       = st_q.opnd; // RULE4 RULE17
              st_d.ea_valid = 1'h1;
            end
            oag_pkg::MD_IDX_NONE, oag_pkg::MD_IDX_SHORT,
            oag_pkg::MD_IDX_LONG, oag_pkg::MD_IIDX_SHORT,
            oag_pkg::MD_IIDX_LONG: begin
              st_d.ea       = idx_sum; // RULE5 RULE13 RULE22
              st_d.ea_valid = 1'h1;
            end
            oag_pkg::MD_IND_SHORT, oag_pkg::MD_BIT_IND: begin
              st_d.ea = {oag_pkg::PAGE_ZERO_HI, st_q.ptr[BW-1:0]}; // RULE11
              st_d.ea_valid = 1'h1;
            end
            oag_pkg::MD_BIT_IND_REL: begin
              st_d.ea = {oag_pkg::PAGE_ZERO_HI, st_q.ptr[BW-1:0]};
              st_d.ea_valid     = 1'h1;
              st_d.target       = target_sum;
              st_d.target_valid = 1'h1;
            end
            oag_pkg::MD_IND_LONG: begin
              st_d.ea       = st_q.ptr; // RULE12 RULE17
              st_d.ea_valid = 1'h1;
            end
            oag_pkg::MD_REL, oag_pkg::MD_REL_IND: begin
              st_d.target       = target_sum; // RULE15
              st_d.target_valid = 1'h1;
            end
            default: begin
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign fetch_ready_out  = st_q.ready;
  assign mem_req_out      = st_q.mem_req;
  assign mem_addr_out     = st_q.mem_addr;
  assign done_out         = st_q.done;
  assign mode_out         = st_q.mode;
  assign index_y_out      = st_q.use_y;
  assign refused_out      = st_q.refused;
  assign length_out       = st_q.length;
  assign ea_out           = st_q.ea;
  assign ea_valid_out     = st_q.ea_valid;
  assign imm_out          = st_q.imm;
  assign imm_valid_out    = st_q.imm_valid;
  assign target_out       = st_q.target;
  assign target_valid_out = st_q.target_valid;

  // checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  AST_INH_LEN: assert property ( // RULE1
    done_out && mode_out == oag_pkg::MD_INHERENT && !refused_out
    |-> length_out == oag_pkg::LEN_OPC + {2'h0, index_y_out})
    else $error("inherent length wrong");
  AST_IMM_VAL: assert property ( // RULE2
    st_q.state == oag_pkg::ST_CALC && st_q.mode == oag_pkg::MD_IMMEDIATE &&
    !st_q.refused
    |=> imm_valid_out && imm_out == $past(st_q.opnd[BW-1:0]) &&
        length_out == oag_pkg::LEN_OPC + oag_pkg::LEN_STEP +
                      {2'h0, index_y_out})
    else $error("immediate value or length wrong");
  AST_SHORT_PAGE0: assert property ( // RULE3
    done_out && ea_valid_out && mode_out inside {oag_pkg::MD_DIR_SHORT,
      oag_pkg::MD_IND_SHORT, oag_pkg::MD_BIT, oag_pkg::MD_IDX_NONE}
    |-> ea_out[AW-1:BW] == oag_pkg::PAGE_ZERO_HI)
    else $error("short form left page zero");
  AST_LONG_LEN: assert property ( // RULE4
    done_out && mode_out == oag_pkg::MD_DIR_LONG && !refused_out
    |-> length_out == oag_pkg::LEN_LONG + {2'h0, index_y_out})
    else $error("long direct length wrong");
  AST_IDX_SUM: assert property ( // RULE5
    st_q.state == oag_pkg::ST_CALC && !st_q.refused &&
    st_q.mode == oag_pkg::MD_IDX_SHORT
    |=> ea_out == AW'($past(st_q.opnd[BW-1:0])) + AW'($past(idx_sel)))
    else $error("indexed sum wrong");
  AST_IDX0_LEN: assert property ( // RULE7
    done_out && mode_out == oag_pkg::MD_IDX_NONE && !refused_out
    |-> length_out == oag_pkg::LEN_OPC + {2'h0, index_y_out})
    else $error("no-offset indexed length wrong");
  AST_PTR_PAGE0: assert property ( // RULE10
    mem_req_out |-> mem_addr_out <= oag_pkg::PTR_LIMIT)
    else $error("pointer outside page zero");
  AST_PTR_WORD: assert property ( // RULE22
    mem_req_out && mem_ack_in && st_q.ptr_cnt == oag_pkg::CNT_TWO
    |=> mem_req_out &&
        mem_addr_out == $past(mem_addr_out) + oag_pkg::ADDR_STEP)
    else $error("second pointer byte not at next address");
  AST_REQ_HOLD: assert property ( // RULE10
    mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out))
    else $error("pointer request dropped before ack");
  AST_REL_RANGE: assert property ( // RULE15
    done_out && target_valid_out
    |-> (AW'(target_out - $past(next_pc)) <= oag_pkg::REL_FWD_MAX) ||
        (AW'(target_out - $past(next_pc)) >= oag_pkg::REL_BACK_MIN))
    else $error("relative target out of range");
  AST_RMW_LONG: assert property ( // RULE18
    done_out && st_q.rmw && mode_out inside {oag_pkg::MD_DIR_LONG,
      oag_pkg::MD_IDX_LONG, oag_pkg::MD_IND_LONG, oag_pkg::MD_IIDX_LONG}
    |-> refused_out && !ea_valid_out && !target_valid_out)
    else $error("long form accepted for read-modify-write");
  AST_DONE_PULSE: assert property (
    done_out |=> !done_out)
    else $error("done held longer than one cycle");

  COV_IIDX_LONG: cover property (
    done_out && mode_out == oag_pkg::MD_IIDX_LONG && index_y_out);
  COV_REL_IND:   cover property (
    done_out && mode_out == oag_pkg::MD_REL_IND);
  COV_BIT_IND_REL: cover property (
    done_out && mode_out == oag_pkg::MD_BIT_IND_REL);
  COV_REFUSED:   cover property (done_out && refused_out);

endmodule

// [logic/oag_pkg.sv]
// shared constants and types of the operand address generator
package oag_pkg;

  // widths
  localparam int ADDR_W = 16;
  localparam int BYTE_W = 8;
  localparam int LEN_W  = 3;

  // prefix byte values
  localparam logic [7:0] SECOND_INDEX_PREFIX          = 8'h90;
  localparam logic [7:0] INDIRECT_SECOND_INDEX_PREFIX = 8'h91;
  localparam logic [7:0] INDIRECT_PREFIX              = 8'h92;

  // address space limits
  localparam logic [7:0]  PAGE_ZERO_HI = 8'h00;
  localparam logic [15:0] PTR_LIMIT    = 16'h0100;
  localparam logic [15:0] ADDR_STEP    = 16'h0001;
  localparam logic [15:0] REL_FWD_MAX  = 16'h007f;
  localparam logic [15:0] REL_BACK_MIN = 16'hff80;

  // byte counts
  localparam logic [1:0]       CNT_ZERO = 2'h0;
  localparam logic [1:0]       CNT_ONE  = 2'h1;
  localparam logic [1:0]       CNT_TWO  = 2'h2;
  localparam logic [LEN_W-1:0] LEN_STEP = 3'h1;
  localparam logic [LEN_W-1:0] LEN_OPC  = 3'h1;
  localparam logic [LEN_W-1:0] LEN_LONG = 3'h3;

  // addressing modes
  typedef enum logic [4:0] {
    MD_INHERENT    = 5'h00,
    MD_IMMEDIATE   = 5'h01,
    MD_DIR_SHORT   = 5'h02,
    MD_DIR_LONG    = 5'h03,
    MD_IDX_NONE    = 5'h04,
    MD_IDX_SHORT   = 5'h05,
    MD_IDX_LONG    = 5'h06,
    MD_IND_SHORT   = 5'h07,
    MD_IND_LONG    = 5'h08,
    MD_IIDX_SHORT  = 5'h09,
    MD_IIDX_LONG   = 5'h0a,
    MD_REL         = 5'h0b,
    MD_REL_IND     = 5'h0c,
    MD_BIT         = 5'h0d,
    MD_BIT_IND     = 5'h0e,
    MD_BIT_REL     = 5'h0f,
    MD_BIT_IND_REL = 5'h10
  } oag_mode_t;

  // prefix seen before the opcode
  typedef enum logic [1:0] {
    PFX_NONE  = 2'h0,
    PFX_Y     = 2'h1,
    PFX_IND   = 2'h2,
    PFX_IND_Y = 2'h3
  } oag_pfx_t;

  // sequencer states, gray along the path
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_OPND = 2'h1,
    ST_PTR  = 2'h3,
    ST_CALC = 2'h2
  } oag_state_t;

endpackage

// [verif/oag_mem_model.sv]
// data memory model answering pointer reads
`timescale 1ns/100ps
module oag_mem_model (
  // clock and pacing
  input  wire logic        clock_in,
  input  wire logic        slow_in,
  // pointer read port
  input  wire logic        mem_req_in,
  input  wire logic [15:0] mem_addr_in,
  output logic             mem_ack_out,
  output logic [7:0]       mem_data_out
);
  logic [1:0] wait_q = 2'h0;
  // one byte per address, wrong data outside the ack cycle
  always @(negedge clock_in) begin
    if (mem_req_in && !mem_ack_out && wait_q >= {slow_in, 1'b0}) begin
      mem_ack_out  <= 1'b1;
      mem_data_out <= mem_addr_in[7:0] ^ mem_addr_in[15:8] ^ 8'h3c;
      wait_q       <= 2'h0;
    end else begin
      mem_ack_out  <= 1'b0;
      mem_data_out <= ~mem_addr_in[7:0] ^ 8'h3c;
      wait_q       <= mem_req_in ? wait_q + 2'h1 : 2'h0;
    end
  end
endmodule

// [verif/tb.sv]
// self-checking bench of the operand address generator
`timescale 1ns/100ps
module tb;
  logic               clock_in, rst_b_in, instr_valid_in, opc_rmw_in, slow;
  logic               fetch_ready_out, mem_req_out, mem_ack_in, done_out;
  logic               index_y_out, refused_out, ea_valid_out, imm_valid_out;
  logic               target_valid_out;
  logic [2:0]         length_out;
  logic [7:0]         instr_byte_in, index_x_in, index_y_in, mem_data_in;
  logic [7:0]         imm_out, b0, b1;
  logic [15:0]        instr_pc_in, mem_addr_out, ea_out, target_out;
  oag_pkg::oag_mode_t opc_mode_in, mode_out;
  logic [27:0]        tab [20];
  int                 err_count, samples_checked;
  oag_operand_address_generator dut_u (
    .clock_in, .rst_b_in, .instr_valid_in, .instr_byte_in, .instr_pc_in,
    .fetch_ready_out, .opc_mode_in, .opc_rmw_in, .index_x_in, .index_y_in,
    .mem_req_out, .mem_addr_out, .mem_ack_in, .mem_data_in, .done_out,
    .mode_out, .index_y_out, .refused_out, .length_out, .ea_out,
    .ea_valid_out, .imm_out, .imm_valid_out, .target_out, .target_valid_out);
  oag_mem_model mem_u (.clock_in, .slow_in(slow), .mem_req_in(mem_req_out),
    .mem_addr_in(mem_addr_out), .mem_ack_out(mem_ack_in),
    .mem_data_out(mem_data_in));
  function automatic logic [7:0] mb(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  task automatic stop_test();
    if (err_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, want, input string what);
    samples_checked++;
    if (got !== want) begin
      err_count++;
      $display("Error %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask
  task automatic send(input logic [7:0] b);
    @(negedge clock_in);
    for (int i = 0; i < 50 && fetch_ready_out !== 1'b1; i++)
      @(negedge clock_in);
    instr_valid_in = 1'b1;
    instr_byte_in  = b;
    @(posedge clock_in);
  endtask
  task automatic run(input int k, input logic corner);
    logic [27:0]        e;
    logic [7:0]         pf, ix, off;
    logic [15:0]        p, pw, ea_x, tg;
    logic [2:0]         n, len;
    logic               ev, iv, tv;
    oag_pkg::oag_mode_t res;
    e = tab[k];
    pf = e[27:20];
    res = oag_pkg::oag_mode_t'(e[8:4]);
    opc_mode_in = oag_pkg::oag_mode_t'(e[16:12]);
    opc_rmw_in = e[1];
    {b0, b1} = corner ? 16'hffff : 16'($urandom);
    index_x_in = corner ? 8'hff : 8'($urandom);
    index_y_in = 8'($urandom);
    instr_pc_in = 16'($urandom);
    slow = 1'($urandom);
    ix = (pf == 8'h90 || pf == 8'h91) ? index_y_in : index_x_in;
    n = (e[8:4] == 5'h00 || e[8:4] == 5'h04) ? 3'h0 :
        (e[8:4] inside {5'h03, 5'h06, 5'h0f, 5'h10}) ? 3'h2 : 3'h1;
    len = n + 3'(pf != 8'h00) + 3'h1;
    if (pf != 8'h00) send(pf);
    send(8'($urandom) & 8'h7f);
    if (n > 3'h0) send(b0);
    if (n > 3'h1) send(b1);
    @(negedge clock_in);
    instr_valid_in = 1'b0;
    for (int i = 0; i < 60 && done_out !== 1'b1; i++)
      @(negedge clock_in);
    p = {8'h00, b0};
    pw = {mb(p), mb(p + 16'h0001)};
    off = (res == oag_pkg::MD_REL) ? b0 :
          (res >= oag_pkg::MD_BIT_REL) ? b1 : mb(p);
    tg = instr_pc_in + 16'(len) + {{8{off[7]}}, off};
    ev = !e[0] && e[8:4] inside {[5'h02:5'h0a], [5'h0d:5'h10]};
    iv = !e[0] && res == oag_pkg::MD_IMMEDIATE;
    tv = !e[0] && e[8:4] inside {5'h0b, 5'h0c, 5'h0f, 5'h10};
    case (res)
      oag_pkg::MD_DIR_SHORT, oag_pkg::MD_BIT,
      oag_pkg::MD_BIT_REL:    ea_x = p;
      oag_pkg::MD_DIR_LONG:   ea_x = {b0, b1};
      oag_pkg::MD_IDX_NONE:   ea_x = {8'h00, ix};
      oag_pkg::MD_IDX_SHORT:  ea_x = p + 16'(ix);
      oag_pkg::MD_IDX_LONG:   ea_x = {b0, b1} + 16'(ix);
      oag_pkg::MD_IND_SHORT, oag_pkg::MD_BIT_IND,
      oag_pkg::MD_BIT_IND_REL: ea_x = {8'h00, mb(p)};
      oag_pkg::MD_IND_LONG:   ea_x = pw;
      oag_pkg::MD_IIDX_SHORT: ea_x = {8'h00, mb(p)} + 16'(ix);
      oag_pkg::MD_IIDX_LONG:  ea_x = pw + 16'(ix);
      default:                ea_x = 16'h0000;
    endcase
    cmp(16'(done_out), 16'h0001, "done");
    cmp(16'(refused_out), 16'(e[0]), "refused");
    cmp(16'(ea_valid_out), 16'(ev), "ea valid");
    cmp(16'(imm_valid_out), 16'(iv), "imm valid");
    cmp(16'(target_valid_out), 16'(tv), "target valid");
    if (ev) cmp(ea_out, ea_x, "address");
    if (iv) cmp(16'(imm_out), 16'(b0), "immediate");
    if (tv) cmp(target_out, tg, "target");
    if (!e[0]) begin
      cmp(16'(length_out), 16'(len), "length");
      cmp(16'(mode_out), 16'(e[8:4]), "mode");
      cmp(16'(index_y_out), 16'(pf == 8'h90 || pf == 8'h91),
          "index y");
    end
  endtask
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  initial begin
    repeat (40000) @(posedge clock_in);
    err_count++;
    stop_test();
  end
  initial begin
    {rst_b_in, instr_valid_in, opc_rmw_in, slow} = 4'h0;
    {instr_byte_in, index_x_in, index_y_in, instr_pc_in} = 40'h0;
    opc_mode_in = oag_pkg::MD_INHERENT;
    err_count = 0;
    samples_checked = 0;
    tab = '{28'h00_00_00_0, 28'h00_01_01_0, 28'h00_02_02_2, 28'h00_03_03_0,
           28'h00_04_04_0, 28'h90_04_04_0, 28'h00_05_05_2, 28'h90_06_06_0,
           28'h92_02_07_0, 28'h92_03_08_0, 28'h92_05_09_0, 28'h91_06_0a_0,
           28'h00_0b_0b_0, 28'h92_0b_0c_0, 28'h00_03_03_3, 28'h91_02_02_1,
           28'h00_0d_0d_2, 28'h92_0d_0e_0, 28'h00_0f_0f_0, 28'h92_0f_10_0};
    void'($urandom(18));
    repeat (8) @(negedge clock_in);
    rst_b_in = 1'b1;
    for (int i = 0; i < 96; i++) begin
      run(i < 20 ? i : int'($urandom_range(19)), i < 20);
    end
    stop_test();
  end
endmodule
